// ---- pkg/fan_ctrl_pkg.sv ----
`default_nettype none
package fan_ctrl_pkg;
  localparam int PCT_W = 7;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] EC_CUTOFF = 7'h0a;
  localparam int TEMP_W = 12;
  localparam int PRES_W = 12;
  localparam int MIN_W = 11;
  localparam logic [10:0] MIN_PER_DAY = 11'h5a0;
  localparam logic [10:0] AUTOCAL_LEAD_MIN = 11'h00a;
  localparam int CLK_HZ = 100000000;
  localparam int CAL_TIME_S = 60;
  localparam longint CAL_CYCLES = longint'(CAL_TIME_S) * longint'(CLK_HZ);
  localparam int PID_TICK_CYCLES = 1000;
  localparam int CNT_W = 33;
  // register byte addresses
  localparam logic [7:0] A_EXH_DAY = 8'h00;
  localparam logic [7:0] A_EXH_NIGHT = 8'h04;
  localparam logic [7:0] A_INT_DAY = 8'h08;
  localparam logic [7:0] A_INT_NIGHT = 8'h0c;
  localparam logic [7:0] A_TEMP_SET = 8'h10;
  localparam logic [7:0] A_PRESSURE = 8'h14;
  localparam logic [7:0] A_CUTOFF = 8'h18;
  localparam logic [7:0] A_SCHED = 8'h1c;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_IRQ_STAT = 8'h28;
  localparam logic [7:0] A_IRQ_EN = 8'h2c;
  localparam logic [7:0] A_IRQ_CLR = 8'h30;
  localparam logic [7:0] A_SPEED = 8'h34;
  // reset values
  localparam logic [6:0] RST_EXH_MIN = 7'h14;
  localparam logic [6:0] RST_EXH_MAX = 7'h50;
  localparam logic [6:0] RST_INT_MIN = 7'h0a;
  localparam logic [6:0] RST_INT_MAX = 7'h32;
  localparam logic [6:0] RST_NEG_PCT = 7'h0a;
  localparam logic [6:0] RST_AC_CUT = 7'h0a;
  localparam logic [7:0] RST_DEV = 8'h14;
  localparam logic [11:0] RST_TEMP_SET = 12'h0fa;
  localparam logic [11:0] RST_PRES_SET = 12'h014;
  localparam logic [10:0] RST_DAY_START = 11'h168;
  localparam logic [10:0] RST_DAY_END = 11'h4b0;
  // interrupt bits
  localparam int IRQ_MIN_UPD = 0;
  localparam int IRQ_MAX_UPD = 1;
  localparam int IRQ_AC_WARN = 2;
  localparam int IRQ_CAL_DONE = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} cal_state_t;
endpackage
`default_nettype wire

// ---- hw/fan_ctrl.sv ----
// Functional notes
// - exhaust speed follows room temperature toward the setpoint.
// - no sensor: intake equals exhaust minus negative-pressure percent, capped at intake MAX.
// - sensor present: PID loop holds measured pressure at pascal setpoint.
// - sensor present: intake capped at exhaust minus negative-pressure percent.
// - EC fan drive below ten percent is switched fully off.
// - separate intake and exhaust AC cutoffs; below cutoff AC fan is off.
// - MIN or MAX below matching AC cutoff raises fan-off warning.
// - exhaust MAX written below MIN also sets MIN, flags notice.
// - exhaust MIN written above MAX also sets MAX, flags notice.
// - exhaust speed never exceeds current-period exhaust maximum.
// - separate day and night MIN/MAX sets selected by current mode.
// - deviation band scales speed linearly between MIN and MAX.
// - pascal setpoint used only while a pressure sensor is attached.
// - calibration request turns all fans off for about one minute.
// - with a sensor attached, auto calibration starts ten minutes before day begins.
// - day mode from start-of-day, night mode from end-of-day.
`default_nettype none
module fan_ctrl
  import fan_ctrl_pkg::*;
#(
  parameter longint CAL_LEN = CAL_CYCLES,
  parameter int PID_TICK = PID_TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // sensors and time, from outside
  input wire logic [TEMP_W-1:0] room_temp_i,
  input wire logic [PRES_W-1:0] pressure_i,
  input wire logic sensor_present_i,
  input wire logic [MIN_W-1:0] time_min_i,
  // fan drives, calibration flag and interrupt
  output logic [PCT_W-1:0] exhaust_ec_o,
  output logic [PCT_W-1:0] intake_ec_o,
  output logic exhaust_ac_on_o,
  output logic intake_ac_on_o,
  output logic [PCT_W-1:0] exhaust_ac_o,
  output logic [PCT_W-1:0] intake_ac_o,
  output logic calibrating_o,
  output logic irq_o
);
  logic [6:0] exh_min_reg [2];
  logic [6:0] exh_max_reg [2];
  logic [6:0] int_min_reg [2];
  logic [6:0] int_max_reg [2];
  logic [6:0] neg_pct_reg, int_cut_reg, exh_cut_reg;
  logic [7:0] dev_reg;
  logic [11:0] temp_set_reg, pres_set_reg;
  logic [10:0] day_start_reg, day_end_reg;
  logic autocal_en_reg, ec_mode_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
  logic [6:0] exh_speed_reg, int_speed_reg;
  logic [31:0] rdata_reg;

  // synchronisers for outside inputs
  logic [TEMP_W-1:0] temp_s1, temp_s2;
  logic [PRES_W-1:0] pres_s1, pres_s2;
  logic [MIN_W-1:0] time_s1, time_s2;
  logic sens_s1, sens_s2;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      temp_s1 <= '0;
      temp_s2 <= '0;
      pres_s1 <= '0;
      pres_s2 <= '0;
      time_s1 <= '0;
      time_s2 <= '0;
      sens_s1 <= 1'b0;
      sens_s2 <= 1'b0;
    end
    else
    begin
      temp_s1 <= room_temp_i;
      temp_s2 <= temp_s1;
      pres_s1 <= pressure_i;
      pres_s2 <= pres_s1;
      time_s1 <= time_i_fix(time_min_i);
      time_s2 <= time_s1;
      sens_s1 <= sensor_present_i;
      sens_s2 <= sens_s1;
    end
  end

  function automatic logic [MIN_W-1:0] time_i_fix(input logic [MIN_W-1:0] t);
    time_i_fix = t;
  endfunction

  // day window, wraps across midnight
  logic is_day;
  always_comb
  begin
    if (day_start_reg <= day_end_reg)
      is_day = (time_s2 >= day_start_reg) && (time_s2 < day_end_reg);
    else
      is_day = (time_s2 >= day_start_reg) || (time_s2 < day_end_reg);
  end
  logic per;
  assign per = ~is_day;

  // register writes
  logic wr_exh_max, wr_exh_min;
  logic [0:0] wr_sel;
  assign wr_exh_max = wr_i && (addr_i == A_EXH_DAY || addr_i == A_EXH_NIGHT);
  assign wr_sel = (addr_i == A_EXH_NIGHT || addr_i == A_INT_NIGHT) ? 1'b1 : 1'b0;
  logic [6:0] wmin, wmax;
  assign wmin = (wdata_i[6:0] > PCT_MAX) ? PCT_MAX : wdata_i[6:0];
  assign wmax = (wdata_i[14:8] > PCT_MAX) ? PCT_MAX : wdata_i[14:8];
  assign wr_exh_min = wr_exh_max;

  // exhaust limits: a write carries min in [6:0] and max in [14:8];
  // bit 16 writes only max, bit 17 only min; the other limit follows when crossed
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exh_min_reg[0] <= RST_EXH_MIN;
      exh_min_reg[1] <= RST_EXH_MIN;
      exh_max_reg[0] <= RST_EXH_MAX;
      exh_max_reg[1] <= RST_EXH_MAX;
    end
    else if (wr_exh_max)
    begin
      if (wdata_i[16])
      begin
        exh_max_reg[wr_sel] <= wmax;
        if (wmax < exh_min_reg[wr_sel])
          exh_min_reg[wr_sel] <= wmax;
      end
      else if (wdata_i[17])
      begin
        exh_min_reg[wr_sel] <= wmin;
        if (wmin > exh_max_reg[wr_sel])
          exh_max_reg[wr_sel] <= wmin;
      end
      else
      begin
        exh_min_reg[wr_sel] <= (wmin > wmax) ? wmax : wmin;
        exh_max_reg[wr_sel] <= wmax;
      end
    end
  end

  logic min_upd, max_upd;
  assign min_upd = wr_exh_max && wdata_i[16] && (wmax < exh_min_reg[wr_sel]);
  assign max_upd = wr_exh_min && !wdata_i[16] && wdata_i[17]
    && (wmin > exh_max_reg[wr_sel]);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      int_min_reg[0] <= RST_INT_MIN;
      int_min_reg[1] <= RST_INT_MIN;
      int_max_reg[0] <= RST_INT_MAX;
      int_max_reg[1] <= RST_INT_MAX;
      neg_pct_reg <= RST_NEG_PCT;
      dev_reg <= RST_DEV;
      temp_set_reg <= RST_TEMP_SET;
      pres_set_reg <= RST_PRES_SET;
      int_cut_reg <= RST_AC_CUT;
      exh_cut_reg <= RST_AC_CUT;
      day_start_reg <= RST_DAY_START;
      day_end_reg <= RST_DAY_END;
      autocal_en_reg <= 1'b0;
      ec_mode_reg <= 1'b1;
      irq_en_reg <= '0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        A_INT_DAY, A_INT_NIGHT:
        begin
          int_min_reg[wr_sel] <= (wmin > wmax) ? wmax : wmin;
          int_max_reg[wr_sel] <= wmax;
        end
        A_TEMP_SET:
        begin
          temp_set_reg <= wdata_i[11:0];
          dev_reg <= wdata_i[23:16];
        end
        A_PRESSURE:
        begin
          pres_set_reg <= wdata_i[11:0];
          neg_pct_reg <= (wdata_i[22:16] > PCT_MAX) ? PCT_MAX : wdata_i[22:16];
        end
        A_CUTOFF:
        begin
          int_cut_reg <= wmin;
          exh_cut_reg <= wmax;
        end
        A_SCHED:
        begin
          day_start_reg <= wdata_i[10:0];
          day_end_reg <= wdata_i[26:16];
        end
        A_CTRL:
        begin
          autocal_en_reg <= wdata_i[0];
          ec_mode_reg <= wdata_i[1];
        end
        A_IRQ_EN: irq_en_reg <= wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // calibration sequencer
  cal_state_t cal_state;
  logic [CNT_W-1:0] cal_cnt;
  logic cal_req, auto_hit, cal_done;
  logic [10:0] autocal_at;
  logic [MIN_W-1:0] last_min;
  assign autocal_at = (day_start_reg >= AUTOCAL_LEAD_MIN) ? day_start_reg - AUTOCAL_LEAD_MIN
    : day_start_reg + MIN_PER_DAY - AUTOCAL_LEAD_MIN;
  assign auto_hit = autocal_en_reg && sens_s2 && (time_s2 == autocal_at)
    && (last_min != time_s2);
  assign cal_req = (wr_i && addr_i == A_CTRL && wdata_i[2]) || auto_hit;
  assign cal_done = (cal_state == CAL_RUN) && (cal_cnt == CNT_W'(CAL_LEN - 1));
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cal_state <= CAL_IDLE;
      cal_cnt <= '0;
      last_min <= '0;
    end
    else
    begin
      last_min <= time_s2;
      case (cal_state)
        CAL_IDLE:
          if (cal_req)
          begin
            cal_state <= CAL_RUN;
            cal_cnt <= '0;
          end
        CAL_RUN:
          if (cal_done)
            cal_state <= CAL_IDLE;
          else
            cal_cnt <= cal_cnt + 1'b1;
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end
  assign calibrating_o = (cal_state == CAL_RUN);

  // exhaust: scale across deviation band above setpoint
  logic [6:0] e_min, e_max, i_min, i_max, exh_next, int_cap, int_next;
  logic [12:0] over;
  logic [20:0] scaled;
  assign e_min = exh_min_reg[per];
  assign e_max = exh_max_reg[per];
  assign i_min = int_min_reg[per];
  assign i_max = int_max_reg[per];
  always_comb
  begin
    over = '0;
    scaled = '0;
    if (temp_s2 <= temp_set_reg)
      exh_next = e_min;
    else
    begin
      over = {1'b0, temp_s2} - {1'b0, temp_set_reg};
      if (dev_reg == 8'h00 || over >= {5'h00, dev_reg})
        exh_next = e_max;
      else
      begin
        scaled = 21'(over) * 21'(e_max - e_min) / 21'(dev_reg);
        exh_next = e_min + scaled[6:0];
      end
    end
    if (exh_next > e_max)
      exh_next = e_max;
  end

  assign int_cap = (exh_next > neg_pct_reg) ? exh_next - neg_pct_reg : 7'h00;

  // pressure loop, a PI-D step every tick
  logic signed [13:0] perr, perr_prev;
  logic signed [19:0] integ;
  logic signed [21:0] pid_out;
  logic [15:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 16'(PID_TICK - 1));
  assign perr = $signed({2'b00, pres_set_reg}) - $signed({2'b00, pres_s2});
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt <= '0;
      integ <= '0;
      perr_prev <= '0;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (!sens_s2 || calibrating_o)
      begin
        integ <= '0;
        perr_prev <= '0;
      end
      else if (tick)
      begin
        // higher pressure than wanted means intake too slow: err > 0 lowers speed
        if (integ - 20'(perr) > 20'sd25600)
          integ <= 20'sd25600;
        else if (integ - 20'(perr) < 20'sd0)
          integ <= 20'sd0;
        else
          integ <= integ - 20'(perr);
        perr_prev <= perr;
      end
    end
  end
  always_comb
  begin
    // small proportional and derivative gains keep the delayed loop from ringing
    pid_out = 22'(integ >>> 8) - 22'(perr >>> 4) - 22'((perr - perr_prev) >>> 5);
    if (pid_out < 0)
      int_next = 7'h00;
    else if (pid_out > 22'(PCT_MAX))
      int_next = PCT_MAX;
    else
      int_next = pid_out[6:0];
    if (!sens_s2)
      int_next = int_cap;
    else if (int_next > int_cap)
      int_next = int_cap;
    if (int_next > i_max)
      int_next = i_max;
    if (int_next < i_min && int_cap >= i_min)
      int_next = i_min;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exh_speed_reg <= '0;
      int_speed_reg <= '0;
    end
    else if (calibrating_o)
    begin
      exh_speed_reg <= '0;
      int_speed_reg <= '0;
    end
    else
    begin
      exh_speed_reg <= exh_next;
      int_speed_reg <= int_next;
    end
  end

  // drive stages
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exhaust_ec_o <= '0;
      intake_ec_o <= '0;
      exhaust_ac_o <= '0;
      intake_ac_o <= '0;
      exhaust_ac_on_o <= 1'b0;
      intake_ac_on_o <= 1'b0;
    end
    else
    begin
      exhaust_ec_o <= (exh_speed_reg < EC_CUTOFF) ? 7'h00 : exh_speed_reg;
      intake_ec_o <= (int_speed_reg < EC_CUTOFF) ? 7'h00 : int_speed_reg;
      exhaust_ac_on_o <= !ec_mode_reg && (exh_speed_reg >= exh_cut_reg);
      intake_ac_on_o <= !ec_mode_reg && (int_speed_reg >= int_cut_reg);
      exhaust_ac_o <= (exh_speed_reg < exh_cut_reg) ? 7'h00 : exh_speed_reg;
      intake_ac_o <= (int_speed_reg < int_cut_reg) ? 7'h00 : int_speed_reg;
    end
  end

  // warning level and interrupts
  logic ac_warn, ac_warn_d;
  assign ac_warn = (exh_min_reg[0] < exh_cut_reg) || (exh_min_reg[1] < exh_cut_reg)
    || (exh_max_reg[0] < exh_cut_reg) || (exh_max_reg[1] < exh_cut_reg)
    || (int_min_reg[0] < int_cut_reg) || (int_min_reg[1] < int_cut_reg)
    || (int_max_reg[0] < int_cut_reg) || (int_max_reg[1] < int_cut_reg);
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_MIN_UPD] = min_upd;
    irq_set[IRQ_MAX_UPD] = max_upd;
    irq_set[IRQ_AC_WARN] = ac_warn && !ac_warn_d;
    irq_set[IRQ_CAL_DONE] = cal_done;
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_stat_reg <= '0;
      ac_warn_d <= 1'b0;
    end
    else
    begin
      ac_warn_d <= ac_warn;
      if (wr_i && addr_i == A_IRQ_CLR)
        irq_stat_reg <= (irq_stat_reg & ~wdata_i[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // read port
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_reg <= '0;
    else if (rd_i)
    begin
      case (addr_i)
        A_EXH_DAY: rdata_reg <= {17'h0, exh_max_reg[0], 1'b0, exh_min_reg[0]};
        A_EXH_NIGHT: rdata_reg <= {17'h0, exh_max_reg[1], 1'b0, exh_min_reg[1]};
        A_INT_DAY: rdata_reg <= {17'h0, int_max_reg[0], 1'b0, int_min_reg[0]};
        A_INT_NIGHT: rdata_reg <= {17'h0, int_max_reg[1], 1'b0, int_min_reg[1]};
        A_TEMP_SET: rdata_reg <= {8'h0, dev_reg, 4'h0, temp_set_reg};
        A_PRESSURE: rdata_reg <= {9'h0, neg_pct_reg, 4'h0, pres_set_reg};
        A_CUTOFF: rdata_reg <= {17'h0, exh_cut_reg, 1'b0, int_cut_reg};
        A_SCHED: rdata_reg <= {5'h0, day_end_reg, 5'h0, day_start_reg};
        A_CTRL: rdata_reg <= {30'h0, ec_mode_reg, autocal_en_reg};
        A_STATUS: rdata_reg <= {28'h0, sens_s2, ac_warn, calibrating_o, is_day};
        A_IRQ_STAT: rdata_reg <= {28'h0, irq_stat_reg};
        A_IRQ_EN: rdata_reg <= {28'h0, irq_en_reg};
        A_SPEED: rdata_reg <= {17'h0, int_speed_reg, 1'b0, exh_speed_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_reg;

  a_ec_cutoff_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(exh_speed_reg) < EC_CUTOFF) |-> exhaust_ec_o == 7'h00)
    else $error("ec exhaust driven below cutoff");
  a_exh_max_clamp: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !calibrating_o |=> exh_speed_reg <= $past(e_max))
    else $error("exhaust above max");
  a_intake_cap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!calibrating_o && sens_s2) |=> int_speed_reg <= $past(int_cap))
    else $error("intake above cap");
  a_intake_nosensor: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!calibrating_o && !sens_s2 && int_cap <= i_max && int_cap >= i_min)
      |=> int_speed_reg == $past(int_cap))
    else $error("intake offset wrong");
  a_cal_fans_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    calibrating_o ##1 calibrating_o |-> exh_speed_reg == 0 && int_speed_reg == 0)
    else $error("fans run in calibration");
  a_min_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    min_upd |=> irq_stat_reg[IRQ_MIN_UPD] && exh_min_reg[$past(wr_sel)] == $past(wmax))
    else $error("min not updated");
  a_max_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    max_upd |=> irq_stat_reg[IRQ_MAX_UPD] && exh_max_reg[$past(wr_sel)] == $past(wmin))
    else $error("max not updated");
  a_speed_range: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    exh_speed_reg <= PCT_MAX && int_speed_reg <= PCT_MAX)
    else $error("speed out of range");
  a_ac_warn_irq: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (ac_warn && !ac_warn_d) |=> irq_stat_reg[IRQ_AC_WARN])
    else $error("ac warning lost");
endmodule
`default_nettype wire

// ---- testbench/fan_room_model.sv ----
`default_nettype none
module fan_room_model
  import fan_ctrl_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // fan drives and sensor plug
  input wire logic [PCT_W-1:0] exhaust_ec_i,
  input wire logic [PCT_W-1:0] intake_ec_i,
  input wire logic attach_i,
  // sensor lines
  output logic [PRES_W-1:0] pressure_o,
  output logic sensor_present_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PRES_W-1:0] room_pa;
  initial
  begin
    pressure_o = 12'h5a5;
    sensor_present_o = 1'b0;
  end
  // four pascal of suction per percent that exhaust leads intake
  always_comb
  begin
    if (exhaust_ec_i > intake_ec_i)
      room_pa = PRES_W'(exhaust_ec_i - intake_ec_i) << 2;
    else
      room_pa = '0;
  end
  // unplugged sensor: line floats, shown as a toggling pattern
  always @(posedge ref_clk_i)
  begin
    sensor_present_o <= attach_i;
    if (attach_i)
      pressure_o <= room_pa;
    else
      pressure_o <= ~pressure_o;
  end
endmodule
`default_nettype wire

// ---- testbench/fan_ctrl_test.sv ----
`default_nettype none
module fan_ctrl_test
  import fan_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [TEMP_W-1:0] room_temp = 12'h064;
  logic [MIN_W-1:0] time_min = 11'h258;
  logic attach = 1'b0;
  logic [PRES_W-1:0] pressure;
  logic present;
  logic [PCT_W-1:0] exh_ec, int_ec, exh_ac, int_ac;
  logic exh_ac_on, int_ac_on, calibrating, irq;
  logic [31:0] d;
  int n_fail = 0;
  int n_checks = 0;

  fan_ctrl #(.CAL_LEN(20), .PID_TICK(4)) i_dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .room_temp_i(room_temp),
    .pressure_i(pressure), .sensor_present_i(present), .time_min_i(time_min),
    .exhaust_ec_o(exh_ec), .intake_ec_o(int_ec), .exhaust_ac_on_o(exh_ac_on),
    .intake_ac_on_o(int_ac_on), .exhaust_ac_o(exh_ac), .intake_ac_o(int_ac),
    .calibrating_o(calibrating), .irq_o(irq));

  fan_room_model i_room (
    .ref_clk_i(ref_clk_i), .exhaust_ec_i(exh_ec), .intake_ec_i(int_ec),
    .attach_i(attach), .pressure_o(pressure), .sensor_present_o(present));

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_env(input logic [11:0] t, input logic [10:0] m);
    @(posedge ref_clk_i);
    room_temp <= t;
    time_min <= m;
    settle(10);
  endtask

  task automatic t_reset;
    rd_reg(A_EXH_DAY);
    chk("exh day lim", {17'h0, RST_EXH_MAX, 1'b0, RST_EXH_MIN}, d);
    rd_reg(A_CUTOFF);
    chk("cutoffs", {17'h0, RST_AC_CUT, 1'b0, RST_AC_CUT}, d);
    rd_reg(8'h3c);
    chk("unmapped", 32'h0, d);
  endtask

  task automatic t_temp;
    logic [11:0] tt[3] = '{12'h064, 12'h104, 12'h190};
    logic [6:0] ee[3] = '{7'h14, 7'h32, 7'h50};
    logic [6:0] ii[3] = '{7'h0a, 7'h28, 7'h32};
    for (int k = 0; k < 3; k++)
    begin
      set_env(tt[k], 11'h258);
      chk("exhaust", ee[k], exh_ec);
      chk("intake", ii[k], int_ec);
    end
    wr_reg(A_PRESSURE, 32'h000a00c8);
    set_env(12'h104, 11'h258);
    chk("intake no sensor", 7'h28, int_ec);
  endtask

  task automatic t_night;
    logic [10:0] tm[4] = '{11'h167, 11'h168, 11'h4af, 11'h4b0};
    logic dy[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr_reg(A_EXH_NIGHT, 32'h0000281e);
    set_env(12'h064, 11'h514);
    chk("night exhaust", 7'h1e, exh_ec);
    for (int k = 0; k < 4; k++)
    begin
      set_env(12'h064, tm[k]);
      rd_reg(A_STATUS);
      chk("is day", dy[k], d[0]);
    end
    set_env(12'h064, 11'h258);
    chk("day exhaust", 7'h14, exh_ec);
  endtask

  task automatic t_limits;
    wr_reg(A_IRQ_EN, 32'hf);
    wr_reg(A_EXH_DAY, 32'h00010f00);
    rd_reg(A_EXH_DAY);
    chk("min follows", 32'h0f0f, d);
    rd_reg(A_IRQ_STAT);
    chk("min notice", 32'h1, d & 32'h3);
    settle(1);
    chk("irq on", 1'b1, irq);
    wr_reg(A_IRQ_CLR, 32'hf);
    wr_reg(A_EXH_DAY, 32'h0002005a);
    rd_reg(A_EXH_DAY);
    chk("max follows", 32'h5a5a, d);
    rd_reg(A_IRQ_STAT);
    chk("max notice", 32'h2, d & 32'h3);
    wr_reg(A_IRQ_CLR, 32'hf);
    settle(1);
    chk("irq off", 1'b0, irq);
    wr_reg(A_CUTOFF, 32'h600a);
    settle(4);
    rd_reg(A_STATUS);
    chk("ac warn", 1'b1, d[2]);
    rd_reg(A_IRQ_STAT);
    chk("ac warn irq", 1'b1, d[IRQ_AC_WARN]);
    wr_reg(A_CUTOFF, 32'h0a0a);
    settle(4);
    rd_reg(A_STATUS);
    chk("ac warn gone", 1'b0, d[2]);
    wr_reg(A_EXH_DAY, 32'h5014);
    wr_reg(A_IRQ_CLR, 32'hf);
  endtask

  task automatic t_cutoff;
    wr_reg(A_EXH_DAY, 32'h0505);
    set_env(12'h064, 11'h258);
    chk("ec below ten", 7'h00, exh_ec);
    wr_reg(A_CTRL, 32'h0);
    wr_reg(A_CUTOFF, 32'h1e0a);
    wr_reg(A_EXH_DAY, 32'h5014);
    set_env(12'h064, 11'h258);
    chk("exh ac off", 8'h00, {exh_ac_on, exh_ac});
    chk("int ac on", 8'h8a, {int_ac_on, int_ac});
    set_env(12'h190, 11'h258);
    chk("exh ac full", 8'hd0, {exh_ac_on, exh_ac});
    wr_reg(A_CTRL, 32'h2);
    wr_reg(A_CUTOFF, 32'h0a0a);
    wr_reg(A_IRQ_CLR, 32'hf);
  endtask

  task automatic t_pressure;
    int over;
    over = 0;
    wr_reg(A_INT_DAY, 32'h640a);
    attach <= 1'b1;
    wr_reg(A_PRESSURE, 32'h000a0050);
    set_env(12'h190, 11'h258);
    for (int k = 0; k < 8000; k++)
    begin
      settle(1);
      if ({1'b0, int_ec} + 8'h0a > {1'b0, exh_ec})
        over++;
      if (k == 3999)
      begin
        chk("pid target", 1'b1, int_ec >= 7'h39 && int_ec <= 7'h3f);
        wr_reg(A_PRESSURE, 32'h000a0000);
      end
    end
    chk("intake cap", 7'h46, int_ec);
    chk("cap kept", 32'h0, over);
    rd_reg(A_SPEED);
    chk("speed reg", {17'h0, 7'h46, 1'b0, 7'h50}, d);
  endtask

  task automatic t_cal;
    int w;
    wr_reg(A_CTRL, 32'h6);
    settle(5);
    chk("cal fans off", 16'h8000, {calibrating, exh_ec, int_ec, exh_ac_on});
    w = 0;
    while (calibrating === 1'b1 && w < 100)
    begin
      settle(1);
      w++;
    end
    chk("cal ends", 1'b0, calibrating);
    rd_reg(A_IRQ_STAT);
    chk("cal done", 1'b1, d[IRQ_CAL_DONE]);
    wr_reg(A_CTRL, 32'h3);
    set_env(12'h190, 11'h15d);
    chk("no early cal", 1'b0, calibrating);
    set_env(12'h190, 11'h15e);
    chk("auto cal", 1'b1, calibrating);
  endtask

  initial
  begin
    #300000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    settle(2);
    t_reset();
    t_temp();
    t_night();
    t_limits();
    t_cutoff();
    t_pressure();
    t_cal();
    give_verdict();
  end
endmodule
`default_nettype wire
